// file: spf_pkg.sv
// Package for the serial port block: register map, field positions,
// reset values, divider settings and the master sequencing states.
// Assumes a 32-bit APB register bus and an 8-bit serial frame.
package spf_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register byte offsets on the bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] DATA_OFS = 8'h08;

    // Control register fields
    localparam int CTRL_MSTR_BIT = 5;
    localparam int CTRL_CPOL_BIT = 4;
    localparam int CTRL_CPHA_BIT = 3;
    localparam int CTRL_EN_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h28;
    localparam logic [7:0] CTRL_WMASK = 8'h3A;

    // Status register fields
    localparam int STAT_RXF_BIT = 7;
    localparam int STAT_OVF_BIT = 5;
    localparam int STAT_TXE_BIT = 3;
    localparam int STAT_RATE_LSB = 0;
    localparam logic [1:0] RATE_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////
    // Bus cycles per serial bit for each rate setting
    localparam int BIT_CYC_DIV2 = 2;
    localparam int BIT_CYC_DIV8 = 8;
    localparam int BIT_CYC_DIV32 = 32;
    localparam int BIT_CYC_DIV128 = 128;
    localparam int DIV_W = 7;

    // Half a bit time, in bus cycles, for a rate setting
    function automatic logic [DIV_W-1:0] half_cycles(input logic [1:0] r);
        case (r)
            2'h0: half_cycles = DIV_W'(BIT_CYC_DIV2 / 2);
            2'h1: half_cycles = DIV_W'(BIT_CYC_DIV8 / 2);
            2'h2: half_cycles = DIV_W'(BIT_CYC_DIV32 / 2);
            default: half_cycles = DIV_W'(BIT_CYC_DIV128 / 2);
        endcase
    endfunction : half_cycles

    // Master clock sequencer
    typedef enum logic [0:0] {
        MS_IDLE = 1'b0,
        MS_RUN = 1'b1
    } spf_mstate_t;

endpackage : spf_pkg

// file: spf_core.sv
// Serial peripheral port: APB registers, slave receive/transmit under an
// external clock, and master clock generation from a free-running divider.
// Assumes the pins are resolved outside; all pin inputs are asynchronous.
//
// Contract
// - Master bit clear: slave, clock is input
// - Full slave byte goes to receive register
// - Slave takes any clock up to bus rate; here only up to a quarter of it
// - Slave loads buffer only before transfer starts
// - Slave start: first edge or select fall
// - Four phase/polarity modes; polarity sets idle
// - Slave drives MISO only while selected
// - Phase 0: MSB driven at select fall
// - No buffer load during active transfer
// - Phase 1: first edge starts, select may stay
// - Phase 1: MSB driven at first edge
// - Master starts on data register write
// - Master first bit: phase-dependent clock start
// - Master divider runs only enabled and master
// - Master clock edges at fixed bus phase
// - Master start within one bit time
// - Both ends use same phase and polarity
// - Status then data read clears full
// - Data write clears empty, load sets it
// - Overrun sets flag, keeps old byte
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps

module spf_core #(
    parameter int BITS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic ss_n_in,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n
);

    ////////////////////////////////////////////////////////////////////
    // Frame length must fit the 8-bit data registers
    if (BITS < 2 || BITS > 8) begin : g_bits_check
        $error("spf_core: BITS must be 2 to 8");
    end

    localparam logic [3:0] LAST_BIT = 4'(BITS - 1);

    logic [7:0] ctrl_ff;
    logic [1:0] rate_ff;
    logic [7:0] tdr_ff;
    logic pend_ff;
    logic [7:0] rdr_ff;
    logic rxf_ff;
    logic ovf_ff;
    logic rxf_arm_ff;
    logic ovf_arm_ff;
    logic [7:0] sh_ff;
    logic shf_ff;
    logic [7:0] rxsh_ff;
    logic [3:0] bits_ff;
    logic busy_ff;
    spf_pkg::spf_mstate_t m_state_ff;
    logic sck_ff;
    logic [spf_pkg::DIV_W-1:0] div_cnt_ff;
    logic [3:0] sy1_ff;
    logic [3:0] sy2_ff;
    logic [3:0] sy3_ff;
    logic [3:0] lvl_ff;

    ////////////////////////////////////////////////////////////////////
    // Control decode
    logic en, mstr, cpol, cpha, run_div;
    assign en = ctrl_ff[spf_pkg::CTRL_EN_BIT];
    assign mstr = ctrl_ff[spf_pkg::CTRL_MSTR_BIT];
    assign cpol = ctrl_ff[spf_pkg::CTRL_CPOL_BIT];
    assign cpha = ctrl_ff[spf_pkg::CTRL_CPHA_BIT];
    assign run_div = en && mstr;

    // APB decode; zero wait states, error on unmapped offsets
    logic acc, wr, rd, hit, wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign hit = (paddr == spf_pkg::CTRL_OFS) ||
                 (paddr == spf_pkg::STAT_OFS) ||
                 (paddr == spf_pkg::DATA_OFS);
    assign wr_ctrl = wr && (paddr == spf_pkg::CTRL_OFS);
    assign wr_stat = wr && (paddr == spf_pkg::STAT_OFS);
    assign wr_data = wr && (paddr == spf_pkg::DATA_OFS);
    assign rd_stat = rd && (paddr == spf_pkg::STAT_OFS);
    assign rd_data = rd && (paddr == spf_pkg::DATA_OFS);
    assign pready = 1'b1;
    assign pslverr = acc && !hit;

    // Read mux
    logic [7:0] stat_rd;
    always_comb begin
        stat_rd = 8'h00;
        stat_rd[spf_pkg::STAT_RXF_BIT] = rxf_ff;
        stat_rd[spf_pkg::STAT_OVF_BIT] = ovf_ff;
        stat_rd[spf_pkg::STAT_TXE_BIT] = !pend_ff;
        stat_rd[spf_pkg::STAT_RATE_LSB +: 2] = rate_ff;
        prdata = 32'h0000_0000;
        if (rd && paddr == spf_pkg::CTRL_OFS) begin
            prdata[7:0] = ctrl_ff;
        end else if (rd_stat) begin
            prdata[7:0] = stat_rd;
        end else if (rd_data) begin
            prdata[7:0] = rdr_ff;
        end
    end

    // Software settings; phase/polarity taken as written, software
    // is expected to disable first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= spf_pkg::CTRL_RESET;
            rate_ff <= spf_pkg::RATE_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= pwdata[7:0] & spf_pkg::CTRL_WMASK;
            end
            if (wr_stat) begin
                rate_ff <= pwdata[spf_pkg::STAT_RATE_LSB +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: bit 0 clock, 1 select, 2 mosi, 3 miso.
    // A level is accepted once stages two and three agree.
    logic [3:0] agree, chg;
    assign agree = ~(sy2_ff ^ sy3_ff);
    assign chg = agree & (sy3_ff ^ lvl_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_ff <= 4'h2;
            sy2_ff <= 4'h2;
            sy3_ff <= 4'h2;
            lvl_ff <= 4'h2;
        end else begin
            sy1_ff <= {miso_in, mosi_in, ss_n_in, sck_in};
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
            lvl_ff <= (agree & sy3_ff) | (~agree & lvl_ff);
        end
    end

    // Slave edge events; each clock level must last two bus cycles, so up to a quarter of the bus clock is tracked
    logic ss_low, slave_on, s_lead, s_trail, ss_fall, ss_rise;
    assign ss_low = !lvl_ff[1];
    assign slave_on = en && !mstr;
    assign s_lead = slave_on && ss_low && chg[0] && (sy3_ff[0] != cpol);
    assign s_trail = slave_on && ss_low && chg[0] && (sy3_ff[0] == cpol);
    assign ss_fall = slave_on && chg[1] && !sy3_ff[1];
    assign ss_rise = chg[1] && sy3_ff[1];

    ////////////////////////////////////////////////////////////////////
    // Master divider: half-bit ticks, free running while enabled master.
    // Edges land on a fixed bus clock phase, never mid-cycle.
    logic tick, m_start, m_tog, m_lead, m_trail, m_stop;
    logic [spf_pkg::DIV_W-1:0] half_m1;
    assign half_m1 = spf_pkg::half_cycles(rate_ff) - spf_pkg::DIV_W'(1);
    assign tick = run_div && (div_cnt_ff >= half_m1);
    assign m_start = tick && (m_state_ff == spf_pkg::MS_IDLE) &&
                     shf_ff && !busy_ff;
    // Phase 0 holds the clock idle for the first half bit
    assign m_tog = tick && (((m_state_ff == spf_pkg::MS_RUN) &&
                   (busy_ff || sck_ff != cpol)) || (m_start && cpha));
    assign m_lead = m_tog && (sck_ff == cpol);
    assign m_trail = m_tog && (sck_ff != cpol);
    assign m_stop = tick && (m_state_ff == spf_pkg::MS_RUN) && !busy_ff &&
                    (sck_ff == cpol);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_ff <= '0;
        end else if (!run_div || tick) begin
            div_cnt_ff <= '0;
        end else begin
            div_cnt_ff <= div_cnt_ff + spf_pkg::DIV_W'(1);
        end
    end

    // Master clock level and run state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_ff <= 1'b0;
            m_state_ff <= spf_pkg::MS_IDLE;
        end else if (!run_div) begin
            sck_ff <= cpol;
            m_state_ff <= spf_pkg::MS_IDLE;
        end else begin
            if (m_tog) begin
                sck_ff <= !sck_ff;
            end
            case (m_state_ff)
                spf_pkg::MS_IDLE: begin
                    if (m_start) begin
                        m_state_ff <= spf_pkg::MS_RUN;
                    end
                end
                spf_pkg::MS_RUN: begin
                    if (m_stop) begin
                        m_state_ff <= spf_pkg::MS_IDLE;
                    end
                end
                default: m_state_ff <= spf_pkg::MS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared shift engine; master and slave feed the same edge events
    logic lead, trail, start_ev, sample_ev, shift_ev, done, bit_in;
    logic accept, load_ev, clr_rx, clr_ov;
    logic [7:0] rx_byte;
    assign lead = mstr ? m_lead : s_lead;
    assign trail = mstr ? m_trail : s_trail;
    assign start_ev = mstr ? m_start :
                      (cpha ? (s_lead && !busy_ff) : ss_fall);
    assign sample_ev = busy_ff && (cpha ? trail : lead);
    assign shift_ev = busy_ff && (cpha ? lead : trail);
    assign done = sample_ev && (bits_ff == LAST_BIT);
    assign bit_in = mstr ? sy3_ff[3] : sy3_ff[2];
    assign rx_byte = {rxsh_ff[6:0], bit_in};
    assign clr_rx = rd_data && rxf_arm_ff;
    assign clr_ov = rd_data && ovf_arm_ff;
    assign accept = !((ovf_ff && !clr_ov) || (rxf_ff && !clr_rx));
    // Buffer moves only between transfers; a byte that is still unsent
    // in the master shift register is not overwritten
    assign load_ev = pend_ff && !busy_ff && !start_ev &&
                     !(mstr && shf_ff);

    // Transfer state; select rising aborts a slave transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff <= 1'b0;
            bits_ff <= 4'h0;
        end else if (!en || (!mstr && ss_rise)) begin
            busy_ff <= 1'b0;
            bits_ff <= 4'h0;
        end else if (start_ev) begin
            busy_ff <= 1'b1;
            bits_ff <= 4'h0;
        end else if (sample_ev) begin
            busy_ff <= !done;
            bits_ff <= done ? 4'h0 : bits_ff + 4'h1;
        end
    end

    // Transmit path; MSB sits on the line from load onward
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff <= 8'h00;
            shf_ff <= 1'b0;
        end else begin
            if (load_ev) begin
                sh_ff <= tdr_ff << (8 - BITS);
            end else if (shift_ev) begin
                sh_ff <= {sh_ff[6:0], 1'b0};
            end
            if (!mstr || m_start) begin
                shf_ff <= 1'b0;
            end else if (load_ev) begin
                shf_ff <= 1'b1;
            end
        end
    end

    // Transmit buffer; a write beats a same-cycle load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdr_ff <= 8'h00;
            pend_ff <= 1'b0;
        end else if (wr_data) begin
            tdr_ff <= pwdata[7:0];
            pend_ff <= 1'b1;
        end else if (load_ev) begin
            pend_ff <= 1'b0;
        end
    end

    // Receive shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxsh_ff <= 8'h00;
        end else if (sample_ev) begin
            rxsh_ff <= rx_byte;
        end
    end

    // Flag clear arming: status read with the flag set, then data read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxf_arm_ff <= 1'b0;
            ovf_arm_ff <= 1'b0;
        end else if (rd_data) begin
            rxf_arm_ff <= 1'b0;
            ovf_arm_ff <= 1'b0;
        end else if (rd_stat) begin
            rxf_arm_ff <= rxf_ff;
            ovf_arm_ff <= ovf_ff;
        end
    end

    // Receive register and flags; a new byte wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdr_ff <= 8'h00;
            rxf_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else begin
            if (done && accept) begin
                rdr_ff <= rx_byte;
                rxf_ff <= 1'b1;
            end else if (clr_rx) begin
                rxf_ff <= 1'b0;
            end
            if (done && !accept) begin
                ovf_ff <= 1'b1;
            end else if (clr_ov) begin
                ovf_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drivers; master select pin is not watched, kept high outside
    assign sck_out = sck_ff;
    assign sck_oe_n = !run_div;
    assign mosi_out = sh_ff[7];
    assign mosi_oe_n = !run_div;
    assign miso_out = sh_ff[7];
    // Released while unselected so other slaves can share the line
    assign miso_oe_n = !(slave_on && ss_low);

    ////////////////////////////////////////////////////////////////////
    // Checks
    slave_clk_in_a: assert property (@(posedge pclk) disable iff (!presetn)
        !mstr |-> sck_oe_n && mosi_oe_n)
        else $error("clock driven while slave");

    miso_select_a: assert property (@(posedge pclk) disable iff (!presetn)
        !miso_oe_n |-> (!lvl_ff[1] && en && !mstr))
        else $error("miso driven while unselected");

    rx_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && accept) |=> (rxf_ff && rdr_ff == $past(rx_byte)))
        else $error("received byte not stored");

    ovf_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && !accept) |=> (ovf_ff && $stable(rdr_ff)))
        else $error("overrun lost old byte");

    busy_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy_ff && pend_ff) |=> pend_ff)
        else $error("buffer moved during transfer");

    txe_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data |=> (pend_ff && !stat_rd[spf_pkg::STAT_TXE_BIT]))
        else $error("empty flag not cleared by write");

    start_lat_a: assert property (@(posedge pclk)
        disable iff (!presetn || !run_div)
        ($rose(shf_ff) && !busy_ff && m_state_ff == spf_pkg::MS_IDLE)
        |-> ##[0:128] (m_state_ff == spf_pkg::MS_RUN))
        else $error("master start too late");

    cpha0_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (m_start && !cpha && run_div) |=> (sck_out == $past(cpol)))
        else $error("phase 0 clock left idle early");

    div_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        !run_div |=> (div_cnt_ff == '0 && m_state_ff == spf_pkg::MS_IDLE))
        else $error("divider ran while not master");

    rxf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_rx && !done) |=> !rxf_ff)
        else $error("full flag not cleared");

endmodule : spf_core

// file: spf_far_end.sv
// Far-end model: an SPI master for slave-mode traffic, and a simple
// clock-polarity-0 slave in either phase for master mode.
// Assumes the bench resolves the pins and calls one task at a time.
`timescale 1ns/10ps

module spf_far_end (
    input wire logic dut_sck,
    input wire logic dut_mosi,
    input wire logic dut_miso,
    input wire logic dut_miso_oe_n,
    input wire logic slv_on,
    input wire logic [7:0] slv_tx,
    output logic sck,
    output logic ss_n,
    output logic mosi,
    output logic miso,
    output logic [7:0] slv_rx
);
    logic [2:0] sidx;
    logic mcpha;

    ////////////////////////////////////////////////////////////////////
    // Idle pins; own select stays high while the block is master
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
        miso = 1'b1;
        slv_rx = 8'h00;
        sidx = 3'h0;
        mcpha = 1'b1;
    end

    // Settle the clock at its idle level before the block is enabled
    task automatic park(input logic cpol);
        sck = cpol;
    endtask : park

    // Answer phase for master mode; phase 0 needs the MSB out at once
    task automatic slave_mode(input logic ph);
        mcpha = ph;
        sidx = ph ? 3'h0 : 3'h1;
        if (!ph) miso = slv_tx[7];
    endtask : slave_mode

    // One byte at 64 ns per bit, MSB first, full duplex
    task automatic xfer(input logic [7:0] tx, input logic cpol,
                        input logic cpha, input logic keep_ss,
                        output logic [7:0] rx);
        rx = 8'h00;
        sck = cpol;
        ss_n = 1'b0;
        if (!cpha) mosi = tx[7];
        #32;
        for (int i = 7; i >= 0; i--) begin
            sck = ~cpol;
            // Undriven line reads inverted so a float never matches
            if (cpha) mosi = tx[i];
            else rx[i] = dut_miso_oe_n ? ~dut_miso : dut_miso;
            #32;
            sck = cpol;
            if (cpha) rx[i] = dut_miso_oe_n ? ~dut_miso : dut_miso;
            else if (i > 0) mosi = tx[i-1];
            #32;
        end
        if (!keep_ss || !cpha) ss_n = 1'b1;
        mosi = ~mosi;
        #32;
    endtask : xfer

    // Leading edges: next bit out in phase 1, capture in phase 0
    always @(posedge dut_sck) begin
        if (!slv_on) begin
            sidx <= 3'h0;
            miso <= ~miso;
        end else if (mcpha) begin
            miso <= slv_tx[3'd7 - sidx];
            sidx <= sidx + 3'd1;
        end else begin
            slv_rx <= {slv_rx[6:0], dut_mosi};
        end
    end

    // Trailing edges: capture in phase 1, next bit out in phase 0
    always @(negedge dut_sck) begin
        if (slv_on && mcpha) begin
            slv_rx <= {slv_rx[6:0], dut_mosi};
        end else if (slv_on) begin
            miso <= slv_tx[3'd7 - sidx];
            sidx <= sidx + 3'd1;
        end
    end
endmodule : spf_far_end

// file: tb_spf_core.sv
// Testbench: slave traffic in all four clock modes, reset values,
// overflow, unmapped access and a master transfer with its start delay.
// Assumes spf_far_end as far side and a zero-wait APB slave.
`timescale 1ns/10ps

module tb_spf_core;
    typedef struct packed {
        logic cpol;
        logic cpha;
        logic [7:0] tx;
        logic [7:0] dtx;
    } spf_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, slv_tx, slv_rx, prx;
    logic [31:0] pwdata, prdata, q;
    logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
    logic f_sck, f_ss_n, f_mosi, f_miso, slv_on;
    int bad_count = 0;
    int num_checks = 0;
    spf_row_t rows [4] = '{'{1'b0, 1'b0, 8'hA5, 8'h3C},
        '{1'b1, 1'b0, 8'h5A, 8'hC3}, '{1'b0, 1'b1, 8'h81, 8'h7E},
        '{1'b1, 1'b1, 8'h0F, 8'hF0}};

    ////////////////////////////////////////////////////////////////////
    // Clock and MISO pins resolved from the output enables
    spf_core spf_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_in(sck_oe_n ? f_sck : sck_out),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .ss_n_in(f_ss_n),
        .mosi_in(f_mosi), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
        .miso_in(miso_oe_n ? f_miso : miso_out), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n));
    spf_far_end spf_far_end_i (.dut_sck(sck_out), .dut_mosi(mosi_out),
        .dut_miso(miso_out), .dut_miso_oe_n(miso_oe_n), .slv_on(slv_on),
        .slv_tx(slv_tx), .sck(f_sck), .ss_n(f_ss_n), .mosi(f_mosi),
        .miso(f_miso), .slv_rx(slv_rx));

    // 250 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; waits an edge first so strobes never collide
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            bad_count++;
            final_report();
        end
    endtask : apb

    function automatic logic [31:0] ctl(input logic m, input logic pol,
                                        input logic ph, input logic en);
        ctl = 32'h0000_0000;
        ctl[spf_pkg::CTRL_MSTR_BIT] = m;
        ctl[spf_pkg::CTRL_CPOL_BIT] = pol;
        ctl[spf_pkg::CTRL_CPHA_BIT] = ph;
        ctl[spf_pkg::CTRL_EN_BIT] = en;
    endfunction : ctl

    // Disable, set mode, park the clock, then enable
    task automatic cfg(input logic m, input logic pol, input logic ph);
        apb(1'b1, spf_pkg::CTRL_OFS, 32'h0000_0000);
        apb(1'b1, spf_pkg::CTRL_OFS, ctl(m, pol, ph, 1'b0));
        spf_far_end_i.park(pol);
        apb(1'b1, spf_pkg::CTRL_OFS, ctl(m, pol, ph, 1'b1));
    endtask : cfg

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        int lim;
        logic [7:0] mtx, mrx;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        slv_on = 1'b0;
        slv_tx = 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Slave byte exchange in every phase/polarity mode
        foreach (rows[r]) begin
            cfg(1'b0, rows[r].cpol, rows[r].cpha);
            apb(1'b1, spf_pkg::DATA_OFS, {24'h00_0000, rows[r].dtx});
            repeat (4) @(posedge pclk);
            apb(1'b0, spf_pkg::STAT_OFS, 32'h0000_0000);
            chk("tx_empty", 32'h1, 32'(q[spf_pkg::STAT_TXE_BIT]));
            spf_far_end_i.xfer(rows[r].tx, rows[r].cpol, rows[r].cpha,
                               1'b0, prx);
            repeat (6) @(posedge pclk);
            chk("miso_oe_n", 32'h1, 32'(miso_oe_n));
            apb(1'b0, spf_pkg::STAT_OFS, 32'h0000_0000);
            chk("rx_full", 32'h1, 32'(q[spf_pkg::STAT_RXF_BIT]));
            apb(1'b0, spf_pkg::DATA_OFS, 32'h0000_0000);
            chk("rx_byte", 32'(rows[r].tx), q);
            apb(1'b0, spf_pkg::STAT_OFS, 32'h0000_0000);
            chk("rx_clear", 32'h0, 32'(q[spf_pkg::STAT_RXF_BIT]));
            chk("miso_byte", 32'(rows[r].dtx), 32'(prx));
            $display("mode row %0d done", r);
        end
        // Two bytes unread, select held low: second one is dropped
        cfg(1'b0, 1'b0, 1'b1);
        // A write in mid-byte waits in the buffer for the next byte
        fork
            spf_far_end_i.xfer(8'h81, 1'b0, 1'b1, 1'b1, prx);
            begin
                repeat (40) @(posedge pclk);
                apb(1'b1, spf_pkg::DATA_OFS, 32'h0000_0096);
            end
        join
        spf_far_end_i.xfer(8'h7E, 1'b0, 1'b1, 1'b0, prx);
        chk("queued_byte", 32'h0000_0096, 32'(prx));
        repeat (6) @(posedge pclk);
        apb(1'b0, spf_pkg::STAT_OFS, 32'h0000_0000);
        chk("overflow", 32'h1, 32'(q[spf_pkg::STAT_OVF_BIT]));
        apb(1'b0, spf_pkg::DATA_OFS, 32'h0000_0000);
        chk("kept_byte", 32'h0000_0081, q);
        $display("overflow test done");
        // Unmapped address refused
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("pslverr", 32'h1, 32'(e));
        chk("unmapped_rd", 32'h0000_0000, q);
        // Reset in mid-run restores the register values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, spf_pkg::CTRL_OFS, 32'h0000_0000);
        chk("ctrl_reset", 32'h0000_0028, q);
        apb(1'b0, spf_pkg::STAT_OFS, 32'h0000_0000);
        chk("stat_reset", 32'h0000_0008, q);
        $display("reset test done");
        // Master at /32 in both phases: start delay and full-duplex byte
        apb(1'b1, spf_pkg::STAT_OFS, 32'h0000_0002);
        for (int ph = 1; ph >= 0; ph--) begin
            cfg(1'b1, 1'b0, 1'(ph));
            mtx = ph ? 8'h59 : 8'hA4;
            mrx = ph ? 8'hC6 : 8'h3B;
            slv_tx <= mrx;
            slv_on <= 1'b1;
            // Enable lands at the last edge; look one edge later
            @(posedge pclk);
            spf_far_end_i.slave_mode(1'(ph));
            chk("sck_oe_n", 32'h0, 32'(sck_oe_n));
            apb(1'b1, spf_pkg::DATA_OFS, {24'h00_0000, mtx});
            // Phase 0 shows its first clock edge half a bit after start
            lim = spf_pkg::BIT_CYC_DIV32 + 2;
            if (ph == 0) lim += spf_pkg::BIT_CYC_DIV32 / 2;
            for (n = 0; n < 60 && sck_out === 1'b0; n++) @(posedge pclk);
            chk("start_delay", 32'h1, 32'(n <= lim));
            for (n = 0; n < 150; n++) begin
                apb(1'b0, spf_pkg::STAT_OFS, 32'h0000_0000);
                if (q[spf_pkg::STAT_RXF_BIT] === 1'b1) break;
            end
            if (n == 150) begin
                bad_count++;
                final_report();
            end
            apb(1'b0, spf_pkg::DATA_OFS, 32'h0000_0000);
            chk("master_rx", {24'h00_0000, mrx}, q);
            // Phase 0 parks the clock half a bit after the last sample
            repeat (spf_pkg::BIT_CYC_DIV32) @(posedge pclk);
            chk("master_tx", {24'h00_0000, mtx}, 32'(slv_rx));
            chk("sck_idle", 32'h0, 32'(sck_out));
            $display("master phase %0d done", ph);
        end
        final_report();
    end
endmodule : tb_spf_core
